// ### nrf_pkg.sv
// shared constants and types for the node request filter block
package nrf_pkg;
   // register bus geometry
   localparam int          NRF_ADDR_W = 12;
   localparam int          NRF_DATA_W = 32;
   localparam int          NRF_STRB_W = NRF_DATA_W / 8;
   // register byte offsets
   localparam logic [11:0] NRF_ASYNC_LOW_SET_OFS  = 12'h108;
   localparam logic [11:0] NRF_ASYNC_LOW_CLR_OFS  = 12'h10c;
   localparam logic [11:0] NRF_PHYS_HIGH_SET_OFS  = 12'h110;
   localparam logic [11:0] NRF_PHYS_HIGH_CLR_OFS  = 12'h114;
   // word alignment bits ignored by the decoder
   localparam int          NRF_ALIGN_BITS = 2;
   // reset value of both filters
   localparam logic [31:0] NRF_FILTER_RESET = 32'h0000_0000;
   // source identifier layout: bus number above node number
   localparam int          NRF_SRC_W   = 16;
   localparam int          NRF_NODE_W  = 6;
   localparam int          NRF_BUS_W   = 10;
   localparam int          NRF_BUS_LSB = 6;
   // bus number that always means "this bus"
   localparam logic [9:0]  NRF_LOCAL_BUS_ALIAS = 10'h3ff;
   // first node held in the upper filter words
   localparam logic [5:0]  NRF_NODE_SPLIT = 6'h20;
   // broadcast node number, never filtered in from the local bus
   localparam logic [5:0]  NRF_NODE_BCAST = 6'h3f;
   // bit of the upper words that admits remote buses
   localparam int          NRF_REMOTE_BIT = 31;
   // bus response codes
   localparam logic [1:0]  NRF_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  NRF_RESP_SLVERR = 2'h2;
   // write channel progress, gray along idle, busy, answer
   typedef enum logic [1:0] {
      NRF_W_IDLE   = 2'b00,
      NRF_W_BUSY   = 2'b01,
      NRF_W_ANSWER = 2'b11
   } nrf_wstate_type;
endpackage

// ### nrf_set_clear_reg.sv
// one read/set/clear filter word with per-bit set and clear masks
module nrf_set_clear_reg
   import nrf_pkg::*;
#(
   parameter int          WIDTH = NRF_DATA_W,
   parameter logic [31:0] RESET = NRF_FILTER_RESET
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] set_mask,
   input  wire logic [WIDTH-1:0] clr_mask,
   output logic      [WIDTH-1:0] value
);
   // ones set, ones clear, zeros keep; set wins if both ever land together
   always_ff @(posedge clk) begin
      if (srst) begin
         value <= RESET[WIDTH-1:0];
      end else begin
         value <= (value & ~clr_mask) | set_mask;
      end
   end
endmodule

// ### nrf_filter.sv
// node request filter: lower async and upper physical filter words
//
// Behaviour
// - low async bit n admits local node n
// - low word acts like the high word
// - low async word: set/clear addresses, reset zero
// - high phys word: set/clear addresses, reset zero
// - physical requests rechecked against phys filter
// - clear phys bit sends request to async context
// - high phys bit 31 admits remote-bus physical
// - high phys bit k routes node k+32, for k up to 30
// - clear async bit: no ack, no queue
// - remote source needs async all-buses bit
// - node comparison only for same-bus sources
module nrf_filter
   import nrf_pkg::*;
(
   input  wire logic                  CORE_CLK,
   input  wire logic                  SRST,
   // register bus
   input  wire logic [NRF_ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire logic [NRF_DATA_W-1:0] S_AXI_WDATA,
   input  wire logic [NRF_STRB_W-1:0] S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   output logic [1:0]                 S_AXI_BRESP,
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   input  wire logic [NRF_ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   output logic [NRF_DATA_W-1:0]      S_AXI_RDATA,
   output logic [1:0]                 S_AXI_RRESP,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY,
   // sibling filter words kept outside this block
   input  wire logic [31:0]           ASYNC_FILTER_HIGH,
   input  wire logic [31:0]           PHYS_FILTER_LOW,
   // this node's bus number
   input  wire logic [NRF_BUS_W-1:0]  LOCAL_BUS_ID,
   // incoming request to classify
   input  wire logic                  REQ_VALID,
   input  wire logic [NRF_SRC_W-1:0]  REQ_SRC_ID,
   input  wire logic                  REQ_PHYS,
   // decision, one cycle after the request
   output logic                       DEC_VALID,
   output logic                       DEC_ACK,
   output logic                       DEC_PHYS_CTX,
   output logic                       DEC_ASYNC_CTX,
   // current filter words for the rest of the link
   output logic [31:0]                ASYNC_FILTER_LOW,
   output logic [31:0]                PHYS_FILTER_HIGH
);
   import nrf_pkg::*;

   // write channel holding state
   nrf_wstate_type              wstate;       // write progress
   nrf_wstate_type              next_wstate;  // write progress, next
   logic                        aw_held;      // address taken, write pending
   logic                        w_held;       // data taken, write pending
   logic [NRF_ADDR_W-1:0]       aw_addr;      // captured write address
   logic [NRF_DATA_W-1:0]       w_data;       // captured write data
   logic [NRF_STRB_W-1:0]       w_strb;       // captured byte strobes
   logic [NRF_DATA_W-1:0]       strb_mask;    // strobes widened to bits
   logic                        aw_fire;      // address handshake
   logic                        w_fire;       // data handshake
   logic                        ar_fire;      // read address handshake
   logic                        do_write;     // both halves held: apply now
   logic                        next_aw_held; // address held, next
   logic                        next_w_held;  // data held, next
   // word-aligned offsets
   logic [NRF_ADDR_W-1:0]       wr_word;      // write offset, low bits cleared
   logic [NRF_ADDR_W-1:0]       rd_word;      // read offset, low bits cleared
   // masks into the filter words
   logic [31:0]                 async_set;    // low async set mask
   logic [31:0]                 async_clr;    // low async clear mask
   logic [31:0]                 phys_set;     // high phys set mask
   logic [31:0]                 phys_clr;     // high phys clear mask
   logic                        wr_hit;       // write offset is mapped
   // request decode
   logic [NRF_NODE_W-1:0]       src_node;     // source node number
   logic [NRF_BUS_W-1:0]        src_bus;      // source bus number
   logic                        src_local;    // source on our own bus
   logic                        node_low;     // node held in the low words
   logic                        node_high;    // node held in the high words
   logic                        async_ok;     // async filter admits the source
   logic                        phys_ok;      // phys filter admits the source
   logic                        low_async_bit; // low async bit of the node
   logic                        remote_async;  // all-buses async bit
   logic                        remote_phys;   // all-buses phys bit
   logic                        high_phys_bit; // high phys bit of the node

   // each of the two filter words owned here has its own set/clear cell
   nrf_set_clear_reg #(.WIDTH(32), .RESET(NRF_FILTER_RESET)) u_async_low (
      .clk      (CORE_CLK),
      .srst     (SRST),
      .set_mask (async_set),
      .clr_mask (async_clr),
      .value    (ASYNC_FILTER_LOW)
   );

   nrf_set_clear_reg #(.WIDTH(32), .RESET(NRF_FILTER_RESET)) u_phys_high (
      .clk      (CORE_CLK),
      .srst     (SRST),
      .set_mask (phys_set),
      .clr_mask (phys_clr),
      .value    (PHYS_FILTER_HIGH)
   );

   // each byte strobe guards its eight data bits
   for (genvar i = 0; i < NRF_DATA_W; i++) begin : g_strb
      assign strb_mask[i] = w_strb[i / 8];
   end

   // handshakes
   assign aw_fire  = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_fire   = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_fire  = S_AXI_ARVALID && S_AXI_ARREADY;
   // the write is applied one cycle after both halves are in, whatever order
   assign do_write = aw_held && w_held;
   assign next_aw_held = aw_fire || (aw_held && !do_write);
   assign next_w_held  = w_fire || (w_held && !do_write);

   // offsets compared as whole words, byte bits ignored
   assign wr_word = {aw_addr[NRF_ADDR_W-1:NRF_ALIGN_BITS], NRF_ALIGN_BITS'(0)};
   assign rd_word = {S_AXI_ARADDR[NRF_ADDR_W-1:NRF_ALIGN_BITS], NRF_ALIGN_BITS'(0)};

   // write decode: ones in the data set or clear, zeros leave bits alone
   always_comb begin
      async_set = '0;
      async_clr = '0;
      phys_set  = '0;
      phys_clr  = '0;
      wr_hit    = 1'b1;
      if (do_write) begin
         case (wr_word)
            NRF_ASYNC_LOW_SET_OFS: begin
               async_set = w_data & strb_mask;
            end
            NRF_ASYNC_LOW_CLR_OFS: begin
               async_clr = w_data & strb_mask;
            end
            NRF_PHYS_HIGH_SET_OFS: begin
               phys_set = w_data & strb_mask;
            end
            NRF_PHYS_HIGH_CLR_OFS: begin
               phys_clr = w_data & strb_mask;
            end
            default: begin
               // unmapped: nothing changes, error answer
               wr_hit = 1'b0;
            end
         endcase
      end
   end

   // write progress: idle, one or both halves held, answer pending
   always_comb begin
      next_wstate = wstate;
      case (wstate)
         NRF_W_IDLE, NRF_W_BUSY: begin
            if (do_write) begin
               next_wstate = NRF_W_ANSWER;
            end else if (next_aw_held || next_w_held) begin
               next_wstate = NRF_W_BUSY;
            end else begin
               next_wstate = NRF_W_IDLE;
            end
         end
         NRF_W_ANSWER: begin
            // answer stands until the master takes it
            if (S_AXI_BREADY) begin
               next_wstate = NRF_W_IDLE;
            end
         end
         default: begin
            next_wstate = NRF_W_IDLE;
         end
      endcase
   end

   // write channel registers
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         wstate        <= NRF_W_IDLE;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= NRF_RESP_OKAY;
      end else begin
         wstate  <= next_wstate;
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         if (aw_fire) begin
            aw_addr <= S_AXI_AWADDR;
         end
         if (w_fire) begin
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         // one write at a time: ready drops while a half waits or the answer stands
         S_AXI_AWREADY <= !next_aw_held && (next_wstate != NRF_W_ANSWER);
         S_AXI_WREADY  <= !next_w_held && (next_wstate != NRF_W_ANSWER);
         S_AXI_BVALID  <= (next_wstate == NRF_W_ANSWER);
         if (do_write) begin
            S_AXI_BRESP <= wr_hit ? NRF_RESP_OKAY : NRF_RESP_SLVERR;
         end
      end
   end

   // read channel: one read at a time, data one cycle after the address
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= '0;
         S_AXI_RRESP   <= NRF_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !ar_fire && !(S_AXI_RVALID && !S_AXI_RREADY);
         if (ar_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= NRF_RESP_OKAY;
            // either address of a pair reads back the live filter word
            case (rd_word)
               NRF_ASYNC_LOW_SET_OFS, NRF_ASYNC_LOW_CLR_OFS: begin
                  S_AXI_RDATA <= ASYNC_FILTER_LOW;
               end
               NRF_PHYS_HIGH_SET_OFS, NRF_PHYS_HIGH_CLR_OFS: begin
                  S_AXI_RDATA <= PHYS_FILTER_HIGH;
               end
               default: begin
                  S_AXI_RDATA <= '0;
                  S_AXI_RRESP <= NRF_RESP_SLVERR;
               end
            endcase
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // source identifier split into bus and node
   assign src_node  = REQ_SRC_ID[NRF_NODE_W-1:0];
   assign src_bus   = REQ_SRC_ID[NRF_BUS_LSB +: NRF_BUS_W];
   // the alias bus number always names our own bus
   assign src_local = (src_bus == LOCAL_BUS_ID) || (src_bus == NRF_LOCAL_BUS_ALIAS);
   assign node_low  = (src_node < NRF_NODE_SPLIT);
   // broadcast node has no filter bit and is never admitted from our own bus
   assign node_high = !node_low && (src_node != NRF_NODE_BCAST);

   // single filter bits that the decision reads
   assign low_async_bit = ASYNC_FILTER_LOW[src_node[NRF_NODE_W-2:0]];
   assign high_phys_bit = PHYS_FILTER_HIGH[src_node[NRF_NODE_W-2:0]];
   assign remote_async  = ASYNC_FILTER_HIGH[NRF_REMOTE_BIT];
   assign remote_phys   = PHYS_FILTER_HIGH[NRF_REMOTE_BIT];

   // acceptance and routing
   always_comb begin
      async_ok = 1'b0;
      phys_ok  = 1'b0;
      if (src_local) begin
         // node compare only for sources on our bus
         if (node_low) begin
            async_ok = low_async_bit;
            phys_ok  = PHYS_FILTER_LOW[src_node[NRF_NODE_W-2:0]];
         end else if (node_high) begin
            // upper nodes follow the same pattern in the high words
            async_ok = ASYNC_FILTER_HIGH[src_node[NRF_NODE_W-2:0]];
            phys_ok  = high_phys_bit;
         end
      end else begin
         async_ok = remote_async;
         phys_ok  = remote_phys;
      end
   end

   // decision registers; a refused source gets no ack and no context
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         DEC_VALID     <= 1'b0;
         DEC_ACK       <= 1'b0;
         DEC_PHYS_CTX  <= 1'b0;
         DEC_ASYNC_CTX <= 1'b0;
      end else begin
         DEC_VALID     <= REQ_VALID;
         DEC_ACK       <= REQ_VALID && async_ok;
         // physical target is checked a second time after the async pass
         DEC_PHYS_CTX  <= REQ_VALID && async_ok && REQ_PHYS && phys_ok;
         // a physical request refused by its phys bit falls back to async
         DEC_ASYNC_CTX <= REQ_VALID && async_ok && !(REQ_PHYS && phys_ok);
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   low_accept_a: assert property (
      REQ_VALID && src_local && node_low |=> DEC_ACK == $past(low_async_bit))
      else $error("low async filter bit not honoured");

   refuse_quiet_a: assert property (
      REQ_VALID && !async_ok |=> DEC_VALID && !DEC_ACK && !DEC_PHYS_CTX && !DEC_ASYNC_CTX)
      else $error("refused request was acknowledged or queued");

   remote_gate_a: assert property (
      REQ_VALID && !src_local |=> DEC_ACK == $past(remote_async))
      else $error("remote source acceptance wrong");

   phys_fallback_a: assert property (
      DEC_VALID && DEC_ACK |-> DEC_PHYS_CTX != DEC_ASYNC_CTX)
      else $error("accepted request not in exactly one context");

   remote_phys_a: assert property (
      REQ_VALID && REQ_PHYS && !src_local && remote_async
      |=> DEC_PHYS_CTX == $past(remote_phys))
      else $error("remote physical routing wrong");

   high_route_a: assert property (
      REQ_VALID && REQ_PHYS && src_local && node_high && async_ok
      |=> DEC_PHYS_CTX == $past(high_phys_bit))
      else $error("upper node physical routing wrong");

   set_bits_a: assert property (
      do_write && (async_set != '0) |=> (ASYNC_FILTER_LOW & $past(async_set)) == $past(async_set))
      else $error("set write did not set bits");

   clear_bits_a: assert property (
      do_write && (phys_clr != '0) |=> (PHYS_FILTER_HIGH & $past(phys_clr)) == '0)
      else $error("clear write did not clear bits");

   write_answer_a: assert property (
      do_write |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write answer missing");
endmodule

// ### nrf_node_model.sv
// partner model: remote 1394 nodes that send request packets to the filter
module nrf_node_model (
   input  wire logic                          clk,
   output logic                               req_valid,
   output logic [nrf_pkg::NRF_SRC_W-1:0]      req_src_id,
   output logic                               req_phys
);
   timeunit 1ns;
   timeprecision 1ps;
   import nrf_pkg::*;

   // idle at time zero: no request on the line
   initial begin
      req_valid  = 1'b0;
      req_src_id = 16'h0000;
      req_phys   = 1'b0;
   end

   // one request packet, held for exactly one cycle
   task automatic send(input logic [9:0] bus, input logic [5:0] node, input logic phys);
      @(posedge clk);
      req_valid  <= 1'b1;
      req_src_id <= {bus, node};
      req_phys   <= phys;
      @(posedge clk);
      req_valid  <= 1'b0;
      // released lines show the inverse, so a stale id never matches by luck
      req_src_id <= ~{bus, node};
      req_phys   <= ~phys;
   endtask
endmodule

// ### tb_nrf_filter.sv
// self-checking bench for the node request filter
module tb_nrf_filter;
   timeunit 1ns;
   timeprecision 1ps;
   import nrf_pkg::*;

   // register row: write address, data, then both expected words
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] lo; logic [31:0] hi;}
      nrf_reg_row_type;
   // request row: source bus, node, kind, expected ack/phys/async
   typedef struct packed {logic [9:0] bus; logic [5:0] node; logic ph; logic [2:0] dec;}
      nrf_req_row_type;

   logic        core_clk = 1'b0;   // 100 MHz
   logic        srst     = 1'b1;   // held for the first 20 cycles
   logic [11:0] awaddr   = '0, araddr = '0;
   logic [31:0] wdata    = '0;
   logic [3:0]  wstrb    = '0;
   logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] async_high = 32'h0000_0001;  // node 32 admitted, remote buses not
   logic [31:0] phys_low   = 32'h8000_0000;  // node 31 goes physical
   logic [9:0]  local_bus  = 10'h005;
   logic        awready, wready, bvalid, arready, rvalid, req_valid, req_phys;
   logic        dec_valid, dec_ack, dec_phys, dec_async;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, async_low, phys_high, rd;
   logic [15:0] req_src;
   logic [1:0]  rs;
   int          err_count = 0, check_count = 0, cycles = 0;

   nrf_reg_row_type regs [4] = '{
      '{NRF_ASYNC_LOW_SET_OFS, 32'h8000_0001, 32'h8000_0001, 32'h0},
      '{NRF_PHYS_HIGH_SET_OFS, 32'hc000_0001, 32'h8000_0001, 32'hc000_0001},
      '{NRF_ASYNC_LOW_CLR_OFS, 32'h0000_0001, 32'h8000_0000, 32'hc000_0001},
      '{NRF_PHYS_HIGH_CLR_OFS, 32'h4000_0000, 32'h8000_0000, 32'h8000_0001}};
   nrf_req_row_type reqs [7] = '{
      '{10'h005, 6'd31, 1'b1, 3'b110}, '{10'h005, 6'd0, 1'b1, 3'b000},
      '{10'h005, 6'd32, 1'b1, 3'b110}, '{10'h3ff, 6'd33, 1'b0, 3'b000},
      '{10'h007, 6'd31, 1'b0, 3'b000}, '{10'h005, 6'd63, 1'b1, 3'b000},
      '{10'h3ff, 6'd31, 1'b0, 3'b101}};

   nrf_filter u_nrf_filter (
      .CORE_CLK(core_clk), .SRST(srst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .ASYNC_FILTER_HIGH(async_high), .PHYS_FILTER_LOW(phys_low), .LOCAL_BUS_ID(local_bus),
      .REQ_VALID(req_valid), .REQ_SRC_ID(req_src), .REQ_PHYS(req_phys),
      .DEC_VALID(dec_valid), .DEC_ACK(dec_ack), .DEC_PHYS_CTX(dec_phys),
      .DEC_ASYNC_CTX(dec_async), .ASYNC_FILTER_LOW(async_low), .PHYS_FILTER_HIGH(phys_high));

   nrf_node_model u_nrf_node_model (
      .clk(core_clk), .req_valid(req_valid), .req_src_id(req_src), .req_phys(req_phys));

   // clock generator
   always #5 core_clk = ~core_clk;

   // hang guard: the whole run needs well under 3000 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         wrap_up();
      end
   end

   // verdict and end of run
   task automatic wrap_up();
      if (err_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // compare one value, report and count a mismatch
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // write: address and data offered together, each released when taken;
   // one edge first, so bready is never lowered and raised in one step
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge core_clk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            ad = 1;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wd = 1;
         end
      end
      do @(posedge core_clk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask

   // read: address held until taken, rready held until data arrives
   task automatic axi_rd(input logic [11:0] a);
      // let an edge pass so back-to-back reads never touch rready twice at once
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge core_clk);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   // both addresses of both pairs read back the current word
   task automatic rd_all(input logic [31:0] lo, input logic [31:0] hi);
      logic [11:0] ofs [4];
      ofs = '{NRF_ASYNC_LOW_SET_OFS, NRF_ASYNC_LOW_CLR_OFS,
              NRF_PHYS_HIGH_SET_OFS, NRF_PHYS_HIGH_CLR_OFS};
      foreach (ofs[i]) begin
         axi_rd(ofs[i]);
         chk("readback", rd, (i < 2) ? lo : hi);
         chk("read resp", {30'h0, rs}, {30'h0, NRF_RESP_OKAY});
      end
      chk("async low port", async_low, lo);
      chk("phys high port", phys_high, hi);
   endtask

   // one request, decision looked at in its single valid cycle
   task automatic req_chk(input nrf_req_row_type r);
      u_nrf_node_model.send(r.bus, r.node, r.ph);
      #1;
      chk("decision", {28'h0, dec_valid, dec_ack, dec_phys, dec_async},
          {28'h0, 1'b1, r.dec});
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      rd_all(32'h0, 32'h0);
      // ordinary cases: set and clear writes, then request decisions
      foreach (regs[i]) begin
         axi_wr(regs[i].a, regs[i].d, 4'hf);
         chk("write resp", {30'h0, rs}, {30'h0, NRF_RESP_OKAY});
         rd_all(regs[i].lo, regs[i].hi);
      end
      foreach (reqs[i])
         req_chk(reqs[i]);
      // remote source once the all-buses bits admit it
      @(posedge core_clk);
      async_high <= 32'h8000_0001;
      req_chk(nrf_req_row_type'{10'h007, 6'd0, 1'b1, 3'b110});
      // physical bits cleared: requests fall back to the async context
      axi_wr(NRF_PHYS_HIGH_CLR_OFS, 32'h8000_0001, 4'hf);
      req_chk(nrf_req_row_type'{10'h007, 6'd0, 1'b1, 3'b101});
      req_chk(nrf_req_row_type'{10'h005, 6'd32, 1'b1, 3'b101});
      // one byte lane only: bits 15:8 set, others untouched
      axi_wr(NRF_ASYNC_LOW_SET_OFS, 32'hffff_ffff, 4'h2);
      chk("strobe set", async_low, 32'h8000_ff00);
      // unmapped write and read are refused without effect
      axi_wr(12'h118, 32'hffff_ffff, 4'hf);
      chk("unmapped write resp", {30'h0, rs}, {30'h0, NRF_RESP_SLVERR});
      chk("unmapped write", async_low, 32'h8000_ff00);
      axi_rd(12'h100);
      chk("unmapped read resp", {30'h0, rs}, {30'h0, NRF_RESP_SLVERR});
      chk("unmapped read", rd, 32'h0);
      // second reset in mid-run clears both words
      @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      rd_all(32'h0, 32'h0);
      wrap_up();
   end
endmodule
